// *** rtl/ats_pkg.sv ***
// package for the asynchronous timer register synchroniser
// Notes on behaviour
// [RL1] writes to timer registers are held, then moved after two oscillator edges
// [RL2] each of the five timer registers owns a separate holding register
// [RL3] compare match is blocked while a counter or compare write is pending
// [RL4] after a timer wake-up one full timer period passes before the next
// [RL5] crystal oscillator runs in async mode except in power-down and standby
// [RL6] timer registers are undefined after deep sleep; software reinitialises
// [RL7] wake-up starts on the timer cycle after the interrupt condition
// [RL8] after wake-up the processor stalls four cycles, then runs the handler
// [RL9] counter reads use a shadow copy refreshed on each timer clock edge; the code does not refresh it while sleeping
// [RL10] interrupt flags reach the processor after three cycles plus a timer cycle
// [RL11] compare output pin is driven from the timer clock domain directly
// [RL12] external clock bit with async mode enables input buffer, stops crystal
// [RL13] software sets the external clock bit before selecting async clocking
// [RL14] async select bit picks io_clock or the oscillator pin as timer clock
// [RL15] changing async select may corrupt timer registers; the code keeps their contents and clears only busy
// [RL16] counter busy flag sets on async write, clears once transferred
// [RL17] software follows the documented sequence when switching clock source
// [RL18] software waits for busy clear before rewriting a timer register
// [RL19] software waits for busy clear before light sleep used for wake-up
// [RL20] software reads counter after a dummy write and busy clear
// [RL21] software waits one second for oscillator start before using the timer
// [RL22] compare and control busy flags behave like the counter busy flag
// [RL23] compare and control reads return holding registers, counter reads timer
// [RL24] in synchronous mode writes act directly and busy flags stay zero
package ats_pkg;
   // ----------------------------------------------------------------
   // register byte offsets on the apb
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_COUNT = 8'h00;
   localparam logic [7:0] OFF_CMP_A = 8'h04;
   localparam logic [7:0] OFF_CMP_B = 8'h08;
   localparam logic [7:0] OFF_CTL_A = 8'h0c;
   localparam logic [7:0] OFF_CTL_B = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_IRQ_EN = 8'h18;
   localparam logic [7:0] OFF_FLAGS = 8'h1c;
   localparam logic [7:0] OFF_LAST = 8'h1c;

   // ----------------------------------------------------------------
   // slot indices, equal to offset / 4
   // ----------------------------------------------------------------
   localparam int SLOT_COUNT = 0;
   localparam int SLOT_CMP_A = 1;
   localparam int SLOT_CMP_B = 2;
   localparam int SLOT_CTL_A = 3;
   localparam int SLOT_CTL_B = 4;
   localparam int NSLOT = 5;
   localparam logic [2:0] IDX_STATUS = 3'h5;
   localparam logic [2:0] IDX_IRQ_EN = 3'h6;
   localparam logic [2:0] IDX_FLAGS = 3'h7;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int ST_EXT_CLK = 6;
   localparam int ST_ASYNC = 5;
   localparam int ST_BUSY_TOP = 4;
   localparam int CS_HI = 2;
   localparam int CS_LO = 0;
   localparam int FL_OVF = 0;
   localparam int FL_CMP_A = 1;
   localparam int FL_CMP_B = 2;
   localparam int NFLAG = 3;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;

   // ----------------------------------------------------------------
   // timing counts
   // ----------------------------------------------------------------
   localparam logic [1:0] XFER_EDGES = 2'h2;
   localparam int FLAG_SYNC_CYC = 3;
   localparam logic [2:0] STALL_CYC = 3'h4;

   // sleep state reported by the power manager
   typedef enum logic [2:0] {
      SLP_RUN = 3'h0,
      SLP_IDLE = 3'h1,
      SLP_ADC = 3'h2,
      SLP_SAVE = 3'h3,
      SLP_DOWN = 3'h4,
      SLP_STBY = 3'h5
   } ats_slp_e;

   // wake-up sequencer
   typedef enum logic [3:0] {
      W_IDLE = 4'h1,
      W_WAIT = 4'h2,
      W_STALL = 4'h4,
      W_REARM = 4'h8
   } ats_wake_e;

   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ats_apb_req_s;
endpackage

// *** rtl/ats_sync2.sv ***
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module ats_sync2 #(
   parameter int W = 1
) (
   input logic clk,
   input logic reset,
   input logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // first stage is read only by the second
   always_ff @(posedge clk) begin
      if (reset) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// *** rtl/ats_timer_sync.sv ***
// asynchronous timer register synchroniser with apb slave
`timescale 1ns/1ps
module ats_timer_sync (
   input logic clk,
   input logic reset,
   input ats_pkg::ats_apb_req_s apb_req,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input logic timer_osc_in,
   input ats_pkg::ats_slp_e sleep_state,
   output logic timer_irq,
   output logic wake_req,
   output logic cpu_stall,
   output logic cmp_out_a,
   output logic cmp_out_b,
   output logic osc_run,
   output logic ext_clk_buf_en
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   localparam int NSLOTW = ats_pkg::NSLOT;

   logic osc_sync;
   logic osc_prev_q;
   logic tick_a;
   logic tick;
   logic as_q;
   logic ext_clock_input_enable_q;
   logic as_chg;
   logic setup;
   logic wr_acc;
   logic [3:0] sel;
   logic [NSLOTW-1:0] wr_hit;
   logic wr_status;
   logic wr_irq_en;
   logic wr_flags;
   logic [7:0] hold_q [ats_pkg::NSLOT];
   logic [1:0] edg_q [ats_pkg::NSLOT];
   logic [NSLOTW-1:0] busy_q;
   logic [NSLOTW-1:0] xfer;
   logic [7:0] xdata [ats_pkg::NSLOT];
   logic [7:0] dest_q [ats_pkg::NSLOT];
   logic [7:0] cnt_q;
   logic [7:0] shadow_q;
   logic running;
   logic ovf;
   logic match_a;
   logic match_b;
   logic [2:0] evt;
   logic [2:0] pend_q;
   logic [2:0] sh_q [ats_pkg::FLAG_SYNC_CYC];
   logic [2:0] flag_q;
   logic [2:0] irq_en_q;
   logic [7:0] rd_mux;
   logic sleeping;
   logic light;
   logic deep;
   ats_pkg::ats_wake_e wst_q;
   logic [2:0] scnt_q;

   // ----------------------------------------------------------------
   // oscillator pin sampling
   // ----------------------------------------------------------------
   ats_sync2 #(.W(1)) u_osc_sync (
      .clk(clk),
      .reset(reset),
      .d(timer_osc_in),
      .q(osc_sync)
   );

   // edge finder works on the synchronised level only
   always_ff @(posedge clk) begin
      if (reset) begin
         osc_prev_q <= 1'b0;
      end else begin
         osc_prev_q <= osc_sync;
      end
   end

   // timer clock choice: every clk, or each oscillator rise
   assign tick_a = osc_sync & ~osc_prev_q;
   assign tick = as_q ? tick_a : 1'b1; // [RL14]

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   // offset decode, shared by read and write paths
   function automatic logic [3:0] reg_sel(input logic [7:0] a);
      logic bad;
      bad = (a[1:0] != 2'h0) || (a > ats_pkg::OFF_LAST);
      return {bad, a[4:2]};
   endfunction

   assign setup = apb_req.psel & ~apb_req.penable;
   assign wr_acc = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
   assign sel = reg_sel(apb_req.paddr);
   assign wr_status = wr_acc & (sel == {1'b0, ats_pkg::IDX_STATUS});
   assign wr_irq_en = wr_acc & (sel == {1'b0, ats_pkg::IDX_IRQ_EN});
   assign wr_flags = wr_acc & (sel == {1'b0, ats_pkg::IDX_FLAGS});
   assign as_chg = wr_status & (apb_req.pwdata[ats_pkg::ST_ASYNC] != as_q);

   // read mux: holding copies for compare and control, shadow for count
   always_comb begin
      rd_mux = ats_pkg::RST_BYTE;
      unique case (sel[2:0])
         3'h0: rd_mux = shadow_q; // [RL9] [RL23]
         3'h1: rd_mux = hold_q[ats_pkg::SLOT_CMP_A]; // [RL23]
         3'h2: rd_mux = hold_q[ats_pkg::SLOT_CMP_B];
         3'h3: rd_mux = hold_q[ats_pkg::SLOT_CTL_A];
         3'h4: rd_mux = hold_q[ats_pkg::SLOT_CTL_B];
         3'h5: rd_mux = {1'b0, ext_clock_input_enable_q, as_q, busy_q[0], busy_q[1],
                         busy_q[2], busy_q[3], busy_q[4]};
         3'h6: rd_mux = {5'h00, irq_en_q};
         3'h7: rd_mux = {5'h00, flag_q};
      endcase
   end

   // no wait states: ready is high in the first access cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata <= sel[3] ? 32'h0000_0000 : {24'h00_0000, rd_mux};
            pslverr <= sel[3];
         end
      end
   end

   // ----------------------------------------------------------------
   // status and mask registers
   // ----------------------------------------------------------------
   // clock source bits; software orders them, hardware just stores
   always_ff @(posedge clk) begin
      if (reset) begin
         as_q <= 1'b0;
         ext_clock_input_enable_q <= 1'b0;
      end else if (wr_status) begin
         as_q <= apb_req.pwdata[ats_pkg::ST_ASYNC]; // [RL14]
         ext_clock_input_enable_q <= apb_req.pwdata[ats_pkg::ST_EXT_CLK]; // [RL13]
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_en_q <= 3'h0;
      end else if (wr_irq_en) begin
         irq_en_q <= apb_req.pwdata[2:0];
      end
   end

   // ----------------------------------------------------------------
   // holding registers, one per timer register
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NSLOTW; i++) begin : g_slot
      assign wr_hit[i] = wr_acc & (sel == 4'(i));
      // sync mode bypasses the holding copy
      assign xdata[i] = as_q ? hold_q[i] : apb_req.pwdata[7:0]; // [RL24]
      assign xfer[i] = as_q ? (busy_q[i] & tick_a &
         (edg_q[i] == ats_pkg::XFER_EDGES - 2'h1)) : wr_hit[i]; // [RL1]

      // a mode change abandons the pending copy unless its transfer edge falls in the same cycle; holding contents are kept, only busy clears
      always_ff @(posedge clk) begin
         if (reset) begin
            hold_q[i] <= ats_pkg::RST_BYTE;
            edg_q[i] <= 2'h0;
            busy_q[i] <= 1'b0;
         end else if (as_chg) begin
            busy_q[i] <= 1'b0; // [RL15]
         end else if (wr_hit[i]) begin
            hold_q[i] <= apb_req.pwdata[7:0]; // [RL2]
            edg_q[i] <= 2'h0;
            busy_q[i] <= as_q; // [RL16] [RL22] [RL24]
         end else if (busy_q[i] && tick_a) begin
            if (xfer[i]) begin
               busy_q[i] <= 1'b0; // [RL16] [RL22]
            end else begin
               edg_q[i] <= edg_q[i] + 2'h1;
            end
         end
      end

      // destination copy in the timer domain
      always_ff @(posedge clk) begin
         if (reset) begin
            dest_q[i] <= ats_pkg::RST_BYTE;
         end else if (xfer[i]) begin
            dest_q[i] <= xdata[i]; // [RL1]
         end
      end
   end

   // ----------------------------------------------------------------
   // counter and compare, timer domain
   // ----------------------------------------------------------------
   assign running = dest_q[ats_pkg::SLOT_CTL_B][ats_pkg::CS_HI:ats_pkg::CS_LO]
      != 3'h0;
   assign ovf = tick & running & (cnt_q == ats_pkg::COUNT_MAX) &
      ~xfer[ats_pkg::SLOT_COUNT];
   // no match while counter or compare copy is still in flight
   assign match_a = tick & running & ~busy_q[ats_pkg::SLOT_COUNT] &
      ~busy_q[ats_pkg::SLOT_CMP_A] &
      (cnt_q == dest_q[ats_pkg::SLOT_CMP_A]); // [RL3]
   assign match_b = tick & running & ~busy_q[ats_pkg::SLOT_COUNT] &
      ~busy_q[ats_pkg::SLOT_CMP_B] &
      (cnt_q == dest_q[ats_pkg::SLOT_CMP_B]); // [RL3]
   assign evt = {match_b, match_a, ovf};

   // the transferred value beats the increment
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q <= ats_pkg::RST_BYTE;
      end else if (xfer[ats_pkg::SLOT_COUNT]) begin
         cnt_q <= dest_count_next();
      end else if (tick && running) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   function automatic logic [7:0] dest_count_next();
      return xdata[ats_pkg::SLOT_COUNT];
   endfunction

   // output pins toggle on the timer edge, never resynchronised
   always_ff @(posedge clk) begin
      if (reset) begin
         cmp_out_a <= 1'b0;
         cmp_out_b <= 1'b0;
      end else begin
         cmp_out_a <= cmp_out_a ^ match_a; // [RL11]
         cmp_out_b <= cmp_out_b ^ match_b; // [RL11]
      end
   end

   // shadow frozen in sleep, so it shows the old count after wake
   always_ff @(posedge clk) begin
      if (reset) begin
         shadow_q <= ats_pkg::RST_BYTE;
      end else if (tick && !sleeping) begin
         shadow_q <= cnt_q; // [RL9]
      end
   end

   // ----------------------------------------------------------------
   // flag synchronisation into the processor domain
   // ----------------------------------------------------------------
   // event waits for the next timer edge, then three clk stages
   always_ff @(posedge clk) begin
      if (reset) begin
         pend_q <= 3'h0;
         for (int k = 0; k < ats_pkg::FLAG_SYNC_CYC; k++) begin
            sh_q[k] <= 3'h0;
         end
      end else begin
         pend_q <= (pend_q & ~{3{tick}}) | evt;
         sh_q[0] <= pend_q & {3{tick}}; // [RL10]
         for (int k = 1; k < ats_pkg::FLAG_SYNC_CYC; k++) begin
            sh_q[k] <= sh_q[k-1]; // [RL10]
         end
      end
   end

   // write one to clear; a set in the same cycle wins
   always_ff @(posedge clk) begin
      if (reset) begin
         flag_q <= 3'h0;
      end else begin
         flag_q <= (flag_q & ~(wr_flags ? apb_req.pwdata[2:0] : 3'h0)) |
            sh_q[ats_pkg::FLAG_SYNC_CYC-1];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         timer_irq <= 1'b0;
      end else begin
         timer_irq <= |(flag_q & irq_en_q) & ~cpu_stall; // [RL8]
      end
   end

   // ----------------------------------------------------------------
   // oscillator control and sleep
   // ----------------------------------------------------------------
   assign sleeping = sleep_state != ats_pkg::SLP_RUN;
   assign deep = (sleep_state == ats_pkg::SLP_DOWN) ||
      (sleep_state == ats_pkg::SLP_STBY);
   assign light = sleeping & ~deep;

   // crystal only without external buffer; halted in deep sleep
   always_ff @(posedge clk) begin
      if (reset) begin
         osc_run <= 1'b0;
         ext_clk_buf_en <= 1'b0;
      end else begin
         osc_run <= as_q & ~ext_clock_input_enable_q & ~deep; // [RL5] [RL12]
         ext_clk_buf_en <= as_q & ext_clock_input_enable_q; // [RL12]
      end
   end

   // ----------------------------------------------------------------
   // wake-up sequencer
   // ----------------------------------------------------------------
   // limitation: deep sleep loses no state here, software must reload [RL6]
   always_ff @(posedge clk) begin
      if (reset) begin
         wst_q <= ats_pkg::W_IDLE;
         wake_req <= 1'b0;
         cpu_stall <= 1'b0;
         scnt_q <= 3'h0;
      end else begin
         wake_req <= 1'b0;
         unique case (wst_q)
            ats_pkg::W_IDLE: begin
               if (light && |(evt & irq_en_q)) begin
                  wst_q <= ats_pkg::W_WAIT;
               end
            end
            ats_pkg::W_WAIT: begin
               if (tick) begin
                  wake_req <= 1'b1; // [RL7]
                  cpu_stall <= 1'b1; // [RL8]
                  scnt_q <= ats_pkg::STALL_CYC - 3'h1;
                  wst_q <= ats_pkg::W_STALL;
               end
            end
            ats_pkg::W_STALL: begin
               if (scnt_q == 3'h0) begin
                  cpu_stall <= 1'b0; // [RL8]
                  wst_q <= ats_pkg::W_REARM;
               end else begin
                  scnt_q <= scnt_q - 3'h1;
               end
            end
            ats_pkg::W_REARM: begin
               // interrupt logic needs a whole timer period to reset
               if (tick) begin
                  wst_q <= ats_pkg::W_IDLE; // [RL4]
               end
            end
            default: wst_q <= ats_pkg::W_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_sync_no_busy: assert property ( // [RL24]
      !as_q |-> busy_q == '0)
      else $error("busy flag set in synchronous mode");

   chk_busy_on_write: assert property ( // [RL16]
      as_q && wr_hit[0] && !as_chg |=> busy_q[0])
      else $error("count busy not set by async write");

   chk_cmp_a_xfer: assert property ( // [RL1]
      as_q && $fell(busy_q[1]) && !$past(as_chg)
      |-> dest_q[1] == $past(hold_q[1]))
      else $error("compare a not moved on busy clear");

   chk_match_blocked: assert property ( // [RL3]
      match_a |-> !busy_q[0] && !busy_q[1])
      else $error("match while write pending");

   chk_osc_deep: assert property ( // [RL5]
      deep |=> !osc_run)
      else $error("oscillator running in deep sleep");

   chk_ext_buf: assert property ( // [RL12]
      ext_clk_buf_en |-> !osc_run)
      else $error("crystal and external buffer both on");

   chk_stall_len: assert property ( // [RL8]
      $rose(cpu_stall) |-> cpu_stall[*4] ##1 !cpu_stall)
      else $error("stall not four cycles");

   chk_flag_delay: assert property ( // [RL10]
      sh_q[0][0] |-> ##2 (sh_q[2][0] ##1 flag_q[0]))
      else $error("overflow flag sync delay wrong");

   chk_pin_cause: assert property ( // [RL11]
      $changed(cmp_out_a) |-> $past(match_a))
      else $error("compare pin moved without match");

   chk_wake_stall: assert property ( // [RL7]
      wake_req |-> cpu_stall && $past(tick))
      else $error("wake not on timer edge");
endmodule

// *** dv/ats_osc_model.sv ***
// behavioural timer oscillator that drives the timer pin
`timescale 1ns/1ps
module ats_osc_model #(
   parameter int HALF_NS = 80
) (
   input wire logic run,
   output logic timer_osc_in
);
   // ---------------------------------------------------------------
   // oscillator
   // ---------------------------------------------------------------
   // stable from the first edge, so the bench skips a settle wait
   // odd start offset keeps the pin unrelated in phase to clk
   initial begin
      timer_osc_in = 1'b0;
      #37;
      forever begin
         if (run) begin
            #(HALF_NS) timer_osc_in = ~timer_osc_in;
         end else begin
            timer_osc_in = 1'b0; // a halted crystal rests low
            #(HALF_NS);
         end
      end
   end
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the asynchronous timer synchroniser
`timescale 1ns/1ps
module testbench;
   logic clk, reset, pready, pslverr, timer_osc_in, timer_irq, wake_req;
   logic cpu_stall, cmp_out_a, cmp_out_b, osc_run, ext_clk_buf_en;
   logic [31:0] prdata;
   ats_pkg::ats_apb_req_s req;
   ats_pkg::ats_slp_e slp;
   int n_fail = 0;
   int comparisons = 0;

   ats_timer_sync ats_timer_sync_i (.clk(clk), .reset(reset),
      .apb_req(req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .timer_osc_in(timer_osc_in), .sleep_state(slp),
      .timer_irq(timer_irq), .wake_req(wake_req), .cpu_stall(cpu_stall),
      .cmp_out_a(cmp_out_a), .cmp_out_b(cmp_out_b), .osc_run(osc_run),
      .ext_clk_buf_en(ext_clk_buf_en));
   // pin stands still while neither crystal nor external buffer is on
   ats_osc_model ats_osc_model_i (.run(osc_run | ext_clk_buf_en),
      .timer_osc_in(timer_osc_in));

   // ---------------------------------------------------------------
   // clock and watchdog
   // ---------------------------------------------------------------
   // 100 MHz system clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // the tests need some 600 cycles, so 10000 means a hang
   initial begin
      #100000;
      n_fail++;
      $display("[ERR] watchdog expected done seen hang");
      results();
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
      int n;
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      chk("pready", 32'h1, {31'h0, pready});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      xfer(1'b1, a, d, r, e);
      chk("write slverr", 32'h0, {31'h0, e});
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      xfer(1'b0, a, 32'h0, r, e);
      chk("read slverr", 32'h0, {31'h0, e});
   endtask

   task automatic rdc(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
      logic [31:0] r;
      rd(a, r);
      chk(what, exp, r);
   endtask

   // polls the busy flags, bounded so a stuck flag cannot hang
   task automatic wait_idle();
      logic [31:0] st;
      int n;
      n = 0;
      do begin
         rd(ats_pkg::OFF_STATUS, st);
         n++;
      end while (st[4:0] !== 5'h00 && n < 40);
      chk("busy idle", 32'h0, {27'h0, st[4:0]});
   endtask

   task automatic results();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   // main sequence
   initial begin
      logic [31:0] v, c0, c1, a0;
      logic [7:0] offs [5];
      logic [7:0] vals [5];
      logic e;
      int n, m;
      offs = '{ats_pkg::OFF_COUNT, ats_pkg::OFF_CMP_A, ats_pkg::OFF_CMP_B,
               ats_pkg::OFF_CTL_A, ats_pkg::OFF_CTL_B};
      vals = '{8'h10, 8'h90, 8'h91, 8'h03, 8'h00};
      req = '0;
      slp = ats_pkg::SLP_RUN;
      reset = 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rdc("status reset", ats_pkg::OFF_STATUS, 32'h0);
      xfer(1'b0, 8'h20, 32'h0, v, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, v);
      xfer(1'b1, 8'h02, 32'h5a, v, e);
      chk("misaligned err", 32'h1, {31'h0, e});
      // synchronous mode: no holding stage at all
      wr(ats_pkg::OFF_CMP_B, 32'h77);
      rdc("sync busy", ats_pkg::OFF_STATUS, 32'h0);
      rdc("sync cmp b", ats_pkg::OFF_CMP_B, 32'h77);
      wr(ats_pkg::OFF_STATUS, 32'h20);
      // each register: busy at once, still busy before two osc edges
      for (int i = 0; i < 5; i++) begin
         wr(offs[i], {24'hffffff, vals[i]});
         rd(ats_pkg::OFF_STATUS, v);
         chk("busy set", 32'h1, {31'h0, v[4-i]});
         if (i > 0) begin
            rdc("holding", offs[i], {24'h0, vals[i]});
         end
         repeat (4) @(posedge clk);
         rd(ats_pkg::OFF_STATUS, v);
         chk("busy held", 32'h1, {31'h0, v[4-i]});
      end
      wait_idle();
      for (int i = 0; i < 5; i++) begin
         rdc("destination", offs[i], {24'h0, vals[i]});
      end
      // counter ticks at the pin rate, one per 16 clk
      wr(ats_pkg::OFF_CTL_B, 32'h01);
      wait_idle();
      rd(ats_pkg::OFF_COUNT, c0);
      repeat (64) @(posedge clk);
      rd(ats_pkg::OFF_COUNT, c1);
      v = {24'h0, c1[7:0] - c0[7:0]};
      chk("ticks", 32'h1, {31'h0, v >= 3 && v <= 5});
      // compare match raises flag, irq and pin
      a0 = {31'h0, cmp_out_a};
      wr(ats_pkg::OFF_IRQ_EN, 32'h02);
      wr(ats_pkg::OFF_CMP_A, {24'h0, c1[7:0] + 8'h06});
      wait_idle();
      n = 0;
      do begin
         rd(ats_pkg::OFF_FLAGS, v);
         n++;
      end while (v[1] !== 1'b1 && n < 60);
      chk("cmp a flag", 32'h1, {31'h0, v[1]});
      chk("irq", 32'h1, {31'h0, timer_irq});
      chk("cmp pin", {31'h0, ~a0[0]}, {31'h0, cmp_out_a});
      chk("cmp pin b", 32'h0, {31'h0, cmp_out_b});
      wr(ats_pkg::OFF_FLAGS, 32'h02);
      rdc("flag cleared", ats_pkg::OFF_FLAGS, 32'h0);
      // wake from power-save on a compare event
      rd(ats_pkg::OFF_COUNT, c0);
      wr(ats_pkg::OFF_CMP_A, {24'h0, c0[7:0] + 8'h08});
      wait_idle();
      slp <= ats_pkg::SLP_SAVE;
      repeat (2) @(posedge clk);
      chk("osc light sleep", 32'h1, {31'h0, osc_run});
      n = 0;
      while (wake_req !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk("wake", 32'h1, {31'h0, wake_req});
      m = 0;
      repeat (9) begin
         if (cpu_stall === 1'b1) m++;
         @(posedge clk);
      end
      chk("stall cycles", 32'h4, m);
      slp <= ats_pkg::SLP_DOWN;
      repeat (3) @(posedge clk);
      chk("osc power-down", 32'h0, {31'h0, osc_run});
      slp <= ats_pkg::SLP_RUN;
      repeat (3) @(posedge clk);
      chk("osc run", 32'h1, {31'h0, osc_run});
      wr(ats_pkg::OFF_STATUS, 32'h00);
      wr(ats_pkg::OFF_STATUS, 32'h40);
      wr(ats_pkg::OFF_STATUS, 32'h60);
      repeat (3) @(posedge clk);
      chk("ext buffer", 32'h1, {31'h0, ext_clk_buf_en});
      chk("crystal off", 32'h0, {31'h0, osc_run});
      wr(ats_pkg::OFF_STATUS, 32'h00);
      rdc("sync status", ats_pkg::OFF_STATUS, 32'h0);
      results();
   end
endmodule
